/* verilog/boot_device.sv */
// Device end: boot sequencer, CPU stall, ROM copy, test reset latch.
// Assumes the host end drives the link; ROM is a simple byte port.
`timescale 1ns/1ps
module boot_device #(
  parameter int unsigned MEM_WORDS = 512
) (
  input  wire logic        CLOCK,
  boot_link_if.device      LINK,
  output logic             CPU_STALL,
  output logic             CPU_RUN,
  output logic [31:0]      CPU_PC,
  output logic             CPU_IRQ_PENDING,
  input  wire logic        CPU_CLEAR_IRQ,
  input  wire logic        BIG_ENDIAN,
  output logic [31:0]      ROM_ADDR,
  output logic             ROM_RD,
  input  wire logic [7:0]  ROM_DATA,
  input  wire logic        ROM_VALID,
  output logic [1:0]       EMU_LATCHED,
  output logic [3:0]       ID_VARIANT,
  output logic             IRQ_BIT
);
  initial begin
    if (MEM_WORDS < boot_pkg::ROM_WORDS) $error("MEM_WORDS too small");
  end

  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_HOST  = 3'b001,
    ST_ROM   = 3'b010,
    ST_DRAIN = 3'b011,
    ST_RUN   = 3'b100
  } state_e;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync, trst_sync;
  wire trst_pin = LINK.trst_n_oe ? LINK.trst_n_out : 1'b0;
  always_ff @(posedge CLOCK) begin
    rst_sync  <= {rst_sync[0], LINK.reset_n};
    trst_sync <= {trst_sync[0], trst_pin};
  end
  wire reset_n = rst_sync[1];
  wire trst_n  = trst_sync[1];
  wire in_rst  = ~reset_n;

  // ----------------------------------------------------------------
  // Memory and boot state
  // ----------------------------------------------------------------
  logic [31:0] mem [MEM_WORDS];
  state_e      state;
  logic [9:0]  rom_count;
  logic        trst_q;
  logic        word_valid;
  logic [31:0] word_out;
  logic [7:0]  wr_index;
  logic [1:0]  emu_pins;
  logic        pci_sel;

  wire boot_host = state == ST_HOST;
  wire host_irq_edge = LINK.host_req & LINK.host_irq;
  wire host_mem  = LINK.host_req & ~LINK.host_irq;
  wire [$clog2(MEM_WORDS)-1:0] host_idx = LINK.host_addr[$clog2(MEM_WORDS)+1:2];

  rom_packer u_packer (
    .clk        (CLOCK),
    .rst        (in_rst),
    .big_endian (BIG_ENDIAN),
    .byte_valid (ROM_VALID & (state == ST_ROM)),
    .byte_in    (ROM_DATA),
    .word_valid (word_valid),
    .word_out   (word_out)
  );

  always_ff @(posedge CLOCK) begin
    if (in_rst) begin
      state           <= ST_RESET;
      CPU_STALL       <= 1'b1;
      CPU_RUN         <= 1'b0;
      CPU_PC          <= boot_pkg::START_ADDR;
      CPU_IRQ_PENDING <= 1'b0;
      IRQ_BIT         <= 1'b0;
      ROM_ADDR        <= boot_pkg::CS1_BASE;
      ROM_RD          <= 1'b0;
      rom_count       <= 10'd0;
      wr_index        <= 8'd0;
      LINK.host_ack   <= 1'b0;
      LINK.host_rdata <= 32'h0000_0000;
      LINK.hpi_used   <= 1'b0;
      LINK.pci_used   <= 1'b0;
      ID_VARIANT      <= 4'h0;
      pci_sel         <= 1'b0;
    end else begin
      LINK.host_ack <= 1'b0;
      ID_VARIANT    <= boot_pkg::VARIANT_VALUE;
      case (state)
        ST_RESET: begin
          pci_sel       <= LINK.pci_select;
          LINK.pci_used <= LINK.pci_select;
          LINK.hpi_used <= ~LINK.pci_select;
          case (boot_pkg::boot_mode_e'(LINK.boot_mode))
            boot_pkg::BOOT_HOST: state <= ST_HOST;
            boot_pkg::BOOT_ROM: begin
              state  <= ST_ROM;
              ROM_RD <= 1'b1;
            end
            default: begin
              state     <= ST_RUN;
              CPU_STALL <= 1'b0;
              CPU_RUN   <= 1'b1;
            end
          endcase
        end
        ST_ROM: begin
          if (ROM_VALID) begin
            ROM_ADDR  <= ROM_ADDR + 32'h0000_0001;
            rom_count <= rom_count + 10'd1;
            if (rom_count == 10'(boot_pkg::ROM_BYTES - 1)) begin
              ROM_RD <= 1'b0;
              state  <= ST_DRAIN;
            end
          end
        end
        ST_DRAIN: begin
          if (!word_valid && wr_index == 8'(boot_pkg::ROM_WORDS - 1) + 8'd1) begin
            state     <= ST_RUN;
            CPU_STALL <= 1'b0;
            CPU_RUN   <= 1'b1;
            CPU_PC    <= boot_pkg::START_ADDR;
          end
        end
        ST_HOST: ;
        ST_RUN: ;
        default: state <= ST_RESET;
      endcase
      if (word_valid) begin
        mem[wr_index] <= word_out;
        wr_index      <= wr_index + 8'd1;
      end
      if (host_mem) begin
        LINK.host_ack <= 1'b1;
        if (LINK.host_write) mem[host_idx] <= LINK.host_wdata;
        else LINK.host_rdata <= mem[host_idx];
      end
      if (host_irq_edge) begin
        LINK.host_ack <= 1'b1;
        if (!IRQ_BIT) begin
          IRQ_BIT <= 1'b1;
          if (boot_host) begin
            state     <= ST_RUN;
            CPU_STALL <= 1'b0;
            CPU_RUN   <= 1'b1;
            CPU_PC    <= boot_pkg::START_ADDR;
          end else if (state == ST_RUN) begin
            CPU_IRQ_PENDING <= 1'b1;
          end
        end
      end else if (CPU_CLEAR_IRQ && state == ST_RUN) begin
        IRQ_BIT         <= 1'b0;
        CPU_IRQ_PENDING <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Emulation pin latch on test reset release
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    emu_pins <= LINK.emulation_mode_pins;
    if (!trst_n) begin
      trst_q <= 1'b0;
    end else begin
      trst_q <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (in_rst) EMU_LATCHED <= 2'b00;
    else if (trst_n && !trst_q && reset_n) EMU_LATCHED <= emu_pins;
  end

endmodule : boot_device

/* verilog/boot_pkg.sv */
// Boot mode and reset control: shared constants, modes and register map.
// Assumes a single 200 MHz clock and AHB-Lite word access on the host side.
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package boot_pkg;
  typedef enum logic [1:0] {
    BOOT_NONE = 2'b00,
    BOOT_HOST = 2'b01,
    BOOT_ROM  = 2'b10
  } boot_mode_e;

  localparam int unsigned ROM_BYTES     = 1024;
  localparam int unsigned ROM_WORDS     = ROM_BYTES / 4;
  localparam logic [31:0] CS1_BASE      = 32'h9000_0000;
  localparam logic [31:0] START_ADDR    = 32'h0000_0000;
  localparam logic [3:0]  VARIANT_VALUE = 4'h1;  // Arbitrary value

  // Controller registers on AHB-Lite, byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ADDR   = 8'h08;
  localparam logic [7:0] REG_WDATA  = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam logic [7:0] REG_CMD    = 8'h14;

  // CTRL fields
  localparam int unsigned CTRL_RESET_N = 0;
  localparam int unsigned CTRL_TRST_N  = 1;
  localparam int unsigned CTRL_MODE    = 2;
  localparam int unsigned CTRL_PCI     = 4;
  localparam int unsigned CTRL_EMU     = 5;
  localparam int unsigned CTRL_CPUCLR  = 7;

  // CMD codes
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_READ  = 2'h2;
  localparam logic [1:0] CMD_IRQ   = 2'h3;
endpackage : boot_pkg

/* verilog/boot_link_if.sv */
// Link between boot device and host-side controller.
// Assumes both ends share CLOCK; the bench ties the ends together.
`timescale 1ns/1ps
interface boot_link_if;
  logic        reset_n;
  logic        trst_n_out;
  logic        trst_n_oe;
  logic [1:0]  boot_mode;
  logic        pci_select;
  logic [1:0]  emulation_mode_pins;
  logic        host_req;
  logic        host_write;
  logic        host_irq;
  logic [31:0] host_addr;
  logic [31:0] host_wdata;
  logic        host_ack;
  logic [31:0] host_rdata;
  logic        hpi_used;
  logic        pci_used;

  modport device (
    input  reset_n, trst_n_out, trst_n_oe, boot_mode, pci_select,
           emulation_mode_pins, host_req, host_write, host_irq,
           host_addr, host_wdata,
    output host_ack, host_rdata, hpi_used, pci_used
  );
  modport host (
    output reset_n, trst_n_out, trst_n_oe, boot_mode, pci_select,
           emulation_mode_pins, host_req, host_write, host_irq,
           host_addr, host_wdata,
    input  host_ack, host_rdata, hpi_used, pci_used
  );
endinterface : boot_link_if

/* verilog/rom_packer.sv */
// Packs bytes into 32-bit words in the selected endian order.
// Assumes one byte per valid pulse from the same clock domain.
`timescale 1ns/1ps
module rom_packer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        big_endian,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_in,
  output logic             word_valid,
  output logic [31:0]      word_out
);
  logic [1:0]  count;
  logic [31:0] shift;
  wire  [31:0] next_word = big_endian ? {shift[23:0], byte_in}
                                      : {byte_in, shift[31:8]};

  always_ff @(posedge clk) begin
    if (rst) begin
      count      <= 2'd0;
      shift      <= 32'h0000_0000;
      word_valid <= 1'b0;
      word_out   <= 32'h0000_0000;
    end else begin
      word_valid <= 1'b0;
      if (byte_valid) begin
        shift <= next_word;
        count <= count + 2'd1;
        if (count == 2'd3) begin
          word_valid <= 1'b1;
          word_out   <= next_word;
        end
      end
    end
  end
endmodule : rom_packer

/* verilog/boot_host.sv */
// Host end: AHB-Lite slave registers steering resets, straps and host port.
// Assumes the device end answers host port requests with host_ack.
`timescale 1ns/1ps
module boot_host (
  input  wire logic        CLOCK,
  input  wire logic        SRST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic [31:0]      HRDATA,
  output logic             HRESP,
  boot_link_if.host        LINK
);
  logic [7:0]  ctrl;
  logic [31:0] addr_reg, wdata_reg, rdata_reg;
  logic        busy;
  logic        dp_write;
  logic [7:0]  dp_addr;
  logic        dp_valid;

  wire take = HSEL & HREADY & HTRANS[1];
  wire [31:0] status = {29'd0, LINK.pci_used, LINK.hpi_used, busy};
  // Decoded in the address phase so read data stands for the whole data phase
  wire [7:0]  rd_sel = HADDR[7:0];
  wire [31:0] rd_mux = (rd_sel == boot_pkg::REG_CTRL)   ? {24'd0, ctrl} :
                       (rd_sel == boot_pkg::REG_STATUS) ? status :
                       (rd_sel == boot_pkg::REG_ADDR)   ? addr_reg :
                       (rd_sel == boot_pkg::REG_WDATA)  ? wdata_reg :
                       (rd_sel == boot_pkg::REG_RDATA)  ? rdata_reg : 32'h0000_0000;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ctrl      <= 8'h00;
      addr_reg  <= 32'h0000_0000;
      wdata_reg <= 32'h0000_0000;
      rdata_reg <= 32'h0000_0000;
      busy      <= 1'b0;
      dp_valid  <= 1'b0;
      dp_write  <= 1'b0;
      dp_addr   <= 8'h00;
      HREADYOUT <= 1'b1;
      HRDATA    <= 32'h0000_0000;
      HRESP     <= 1'b0;
      LINK.host_req <= 1'b0;
      LINK.host_write <= 1'b0;
      LINK.host_irq <= 1'b0;
    end else begin
      dp_valid <= take;
      if (take) begin
        dp_write <= HWRITE;
        dp_addr  <= HADDR[7:0];
      end
      if (take && !HWRITE) HRDATA <= rd_mux;
      if (dp_valid && dp_write) begin
        case (dp_addr)
          boot_pkg::REG_CTRL:  ctrl      <= HWDATA[7:0];
          boot_pkg::REG_ADDR:  addr_reg  <= HWDATA;
          boot_pkg::REG_WDATA: wdata_reg <= HWDATA;
          boot_pkg::REG_CMD: if (!busy && HWDATA[1:0] != 2'd0) begin
            busy            <= 1'b1;
            LINK.host_req   <= 1'b1;
            LINK.host_write <= HWDATA[1:0] == boot_pkg::CMD_WRITE;
            LINK.host_irq   <= HWDATA[1:0] == boot_pkg::CMD_IRQ;
          end
          default: ;
        endcase
      end
      if (LINK.host_req) LINK.host_req <= 1'b0;
      if (busy && LINK.host_ack) begin
        busy <= 1'b0;
        if (!LINK.host_write && !LINK.host_irq) rdata_reg <= LINK.host_rdata;
      end
    end
  end

  always_comb begin
    LINK.reset_n             = ctrl[boot_pkg::CTRL_RESET_N];
    LINK.trst_n_out          = ctrl[boot_pkg::CTRL_TRST_N];
    LINK.trst_n_oe           = ctrl[boot_pkg::CTRL_TRST_N];
    LINK.boot_mode           = ctrl[boot_pkg::CTRL_MODE +: 2];
    LINK.pci_select          = ctrl[boot_pkg::CTRL_PCI];
    LINK.emulation_mode_pins = ctrl[boot_pkg::CTRL_EMU +: 2];
    LINK.host_addr           = addr_reg;
    LINK.host_wdata          = wdata_reg;
  end
endmodule : boot_host

/* verif/boot_props.sv */
// Concurrent checks on the boot link and on the CPU-side outputs.
// Assumes one clock; SRST resets the host end, link reset_n the device.
`timescale 1ns/1ps
module boot_props (
  input wire logic        CLOCK,
  input wire logic        SRST,
  input wire logic        reset_n,
  input wire logic        trst_n_out,
  input wire logic        trst_n_oe,
  input wire logic [1:0]  boot_mode,
  input wire logic        pci_select,
  input wire logic [1:0]  emulation_mode_pins,
  input wire logic        host_req,
  input wire logic        host_irq,
  input wire logic        host_ack,
  input wire logic        hpi_used,
  input wire logic        pci_used,
  input wire logic        CPU_STALL,
  input wire logic        CPU_RUN,
  input wire logic [31:0] CPU_PC,
  input wire logic        CPU_CLEAR_IRQ,
  input wire logic        ROM_RD,
  input wire logic [1:0]  EMU_LATCHED,
  input wire logic [3:0]  ID_VARIANT,
  input wire logic        IRQ_BIT
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  // Undriven test reset reads low
  wire trst_line = trst_n_oe & trst_n_out;
  // Long hold, since device reset goes through a synchroniser
  sequence s_dev_up;
    reset_n [*8];
  endsequence
  sequence s_trst_rise;
    $rose(trst_line);
  endsequence
  a_reset_holds: assert property ((!reset_n) [*5] |-> !CPU_RUN && ID_VARIANT == 4'h0)
    else $error("CPU runs in reset");
  a_variant_up: assert property (s_dev_up |-> ID_VARIANT == boot_pkg::VARIANT_VALUE)
    else $error("variant wrong");
  a_none_runs: assert property (s_dev_up ##0 boot_mode == boot_pkg::BOOT_NONE |-> CPU_RUN && !CPU_STALL)
    else $error("no boot not running");
  a_host_start: assert property (host_req && host_irq && boot_mode == boot_pkg::BOOT_HOST && CPU_STALL
    |-> ##[1:4] CPU_RUN && !CPU_STALL) else $error("stall not released");
  a_irq_mode: assert property (host_irq && boot_mode != boot_pkg::BOOT_HOST && ROM_RD
    |=> CPU_STALL) else $error("irq released stall");
  a_irq_hold: assert property (reset_n [*3] ##0 IRQ_BIT && !CPU_CLEAR_IRQ |=> IRQ_BIT)
    else $error("irq bit lost");
  a_rom_stall: assert property (ROM_RD |-> CPU_STALL && !CPU_RUN)
    else $error("CPU runs during copy");
  a_start_zero: assert property ($rose(CPU_RUN) |-> CPU_PC == boot_pkg::START_ADDR)
    else $error("start address wrong");
  a_ack_next: assert property (host_req |-> ##[1:3] host_ack)
    else $error("no host ack");
  a_port_pick: assert property (host_ack && boot_mode == boot_pkg::BOOT_HOST
    |-> (pci_select ? pci_used : hpi_used)) else $error("wrong host port");
  a_emu_latch: assert property (s_dev_up ##0 s_trst_rise
    |-> ##[2:5] EMU_LATCHED == emulation_mode_pins) else $error("emu not latched");
endmodule : boot_props

/* verif/test_boot_mode_reset_control.sv */
// Self-checking bench: host end on AHB-Lite, device end on the link.
// Assumes the ROM answers one byte every other cycle while ROM_RD is high, modelled here.
`timescale 1ns/1ps
module test_boot_mode_reset_control;
  logic        CLOCK = 1'b0, SRST = 1'b1, HWRITE = 1'b0, rd_phase = 1'b0;
  logic        CPU_CLEAR_IRQ = 1'b0, BIG_ENDIAN = 1'b0, ROM_VALID = 1'b0;
  logic [7:0]  ROM_DATA = 8'h00;
  logic        want_chk = 1'b0;
  logic [1:0]  HTRANS = 2'h0, EMU_LATCHED, em;
  logic [31:0] HADDR = 32'h0000_0000, HWDATA = 32'h0000_0000, HRDATA, CPU_PC, ROM_ADDR, d;
  logic        HREADYOUT, CPU_STALL, CPU_RUN, CPU_IRQ_PENDING, ROM_RD, IRQ_BIT;
  logic [3:0]  ID_VARIANT;
  logic [31:0] exp_q[$];
  int          n_fail = 0, cmp_count = 0;
  integer      seed = 32'hba99_f846;

  always #2.5 CLOCK = ~CLOCK;

  boot_link_if link ();
  boot_host i_boot_host (.CLOCK, .SRST, .HSEL(1'b1), .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2),
    .HWDATA, .HREADY(HREADYOUT), .HREADYOUT, .HRDATA, .HRESP(), .LINK(link));
  boot_device i_boot_device (.CLOCK, .LINK(link), .CPU_STALL, .CPU_RUN, .CPU_PC,
    .CPU_IRQ_PENDING, .CPU_CLEAR_IRQ, .BIG_ENDIAN, .ROM_ADDR, .ROM_RD, .ROM_DATA,
    .ROM_VALID, .EMU_LATCHED, .ID_VARIANT, .IRQ_BIT);
  boot_props i_boot_props (.CLOCK, .SRST, .reset_n(link.reset_n),
    .trst_n_out(link.trst_n_out), .trst_n_oe(link.trst_n_oe), .boot_mode(link.boot_mode),
    .pci_select(link.pci_select), .emulation_mode_pins(link.emulation_mode_pins),
    .host_req(link.host_req), .host_irq(link.host_irq), .host_ack(link.host_ack),
    .hpi_used(link.hpi_used), .pci_used(link.pci_used), .CPU_STALL, .CPU_RUN, .CPU_PC,
    .CPU_CLEAR_IRQ, .ROM_RD, .EMU_LATCHED, .ID_VARIANT, .IRQ_BIT);

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  task automatic give_up();
    n_fail++;
    end_sim();
  endtask : give_up

  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp

  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge CLOCK);
      k++;
    end while (HREADYOUT !== 1'b1 && k < 100);
    if (HREADYOUT !== 1'b1) give_up();
  endtask : wait_rdy

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] r);
    HADDR <= {24'h00_0000, a};
    HTRANS <= 2'h2;
    HWRITE <= w;
    wait_rdy();
    HTRANS <= 2'h0;
    HWDATA <= wd;
    rd_phase <= ~w & want_chk;
    wait_rdy();
    r = HRDATA;
    rd_phase <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] r;
    bus(a, 1'b1, wd, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    exp_q.push_back(e);
    want_chk = 1'b1;
    bus(a, 1'b0, 32'h0000_0000, r);
    want_chk = 1'b0;
  endtask : rd

  // Busy is polled on a raw read; its value is not an expectation
  task automatic cmd(input logic [1:0] c);
    logic [31:0] r;
    int k;
    wr(boot_pkg::REG_CMD, {30'h0, c});
    k = 0;
    do begin
      bus(boot_pkg::REG_STATUS, 1'b0, 32'h0000_0000, r);
      k++;
    end while (r[0] !== 1'b0 && k < 50);
    if (r[0] !== 1'b0) give_up();
  endtask : cmd

  task automatic ctrl(input logic r, input logic t, input logic [1:0] m, input logic p,
                      input logic [1:0] e);
    wr(boot_pkg::REG_CTRL, {25'h0, e, p, m, t, r});
  endtask : ctrl

  // Extra edges let the reset pulse cross the synchroniser
  task automatic restart(input logic [1:0] m, input logic p, input logic [1:0] e);
    ctrl(1'b0, 1'b0, m, p, e);
    ctrl(1'b1, 1'b0, m, p, e);
    repeat (6) @(posedge CLOCK);
  endtask : restart

  task automatic wait_run();
    int k;
    k = 0;
    while (CPU_RUN !== 1'b1 && k < 6000) begin
      @(posedge CLOCK);
      k++;
    end
    if (CPU_RUN !== 1'b1) give_up();
  endtask : wait_run

  // ---------------------------------------------------------------
  // Read monitor and ROM responder
  // ---------------------------------------------------------------
  always @(posedge CLOCK) begin
    if (rd_phase && HREADYOUT === 1'b1) begin
      cmp(exp_q.pop_front(), HRDATA);
    end
  end

  // Data toggles between bytes so a stale byte is never reused
  always @(posedge CLOCK) begin
    ROM_VALID <= ROM_RD & ~ROM_VALID;
    ROM_DATA <= (ROM_RD & ~ROM_VALID) ? (ROM_ADDR[7:0] ^ 8'h5a) : ~ROM_DATA;
  end

  initial begin
    repeat (3) @(posedge CLOCK);
    SRST <= 1'b0;
    @(posedge CLOCK);
    rd(boot_pkg::REG_CTRL, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    repeat (4) @(posedge CLOCK);
    cmp(32'h0000_0000, {28'h0, ID_VARIANT[3:1], CPU_RUN | ID_VARIANT[0]});
    for (int p = 0; p < 2; p++) begin
      restart(boot_pkg::BOOT_HOST, p[0], 2'h0);
      cmp(32'h0000_0001, {31'h0, CPU_STALL});
      cmp({28'h0, boot_pkg::VARIANT_VALUE}, {28'h0, ID_VARIANT});
      d = $random(seed);
      wr(boot_pkg::REG_ADDR, 32'h0000_0010);
      wr(boot_pkg::REG_WDATA, d);
      cmd(boot_pkg::CMD_WRITE);
      cmd(boot_pkg::CMD_READ);
      rd(boot_pkg::REG_RDATA, d);
      rd(boot_pkg::REG_STATUS, p[0] ? 32'h0000_0004 : 32'h0000_0002);
      cmd(boot_pkg::CMD_IRQ);
      wait_run();
      cmp(boot_pkg::START_ADDR, CPU_PC);
      cmp(32'h0000_0000, {30'h0, CPU_STALL, CPU_IRQ_PENDING});
      cmd(boot_pkg::CMD_IRQ);
      cmp(32'h0000_0001, {31'h0, IRQ_BIT});
      cmp(32'h0000_0000, {31'h0, CPU_IRQ_PENDING});
      CPU_CLEAR_IRQ <= 1'b1;
      @(posedge CLOCK);
      CPU_CLEAR_IRQ <= 1'b0;
      repeat (2) @(posedge CLOCK);
      cmp(32'h0000_0000, {31'h0, IRQ_BIT});
      cmd(boot_pkg::CMD_IRQ);
      cmp(32'h0000_0001, {31'h0, CPU_IRQ_PENDING});
    end
    for (int e = 0; e < 2; e++) begin
      BIG_ENDIAN <= e[0];
      restart(boot_pkg::BOOT_ROM, 1'b0, 2'h0);
      cmd(boot_pkg::CMD_IRQ);
      cmp(32'h0000_0001, {31'h0, CPU_STALL});
      wait_run();
      cmp(boot_pkg::START_ADDR, CPU_PC);
      wr(boot_pkg::REG_ADDR, 32'h0000_0000);
      cmd(boot_pkg::CMD_READ);
      rd(boot_pkg::REG_RDATA, e[0] ? 32'h5a5b_5859 : 32'h5958_5b5a);
    end
    em = 2'($random(seed));
    restart(boot_pkg::BOOT_NONE, 1'b0, em);
    wait_run();
    cmp(boot_pkg::START_ADDR, CPU_PC);
    cmp(32'h0000_0000, {31'h0, CPU_STALL});
    ctrl(1'b1, 1'b1, boot_pkg::BOOT_NONE, 1'b0, em);
    repeat (8) @(posedge CLOCK);
    cmp({30'h0, em}, {30'h0, EMU_LATCHED});
    end_sim();
  end
endmodule : test_boot_mode_reset_control
